// ===== common/rc_regs.vh
// constants for the locked indirect clock register port
`ifndef RC_REGS_VH
`define RC_REGS_VH
// key codes and lock state codes
`define RC_KEY_FIRST     8'hA5
`define RC_KEY_SECOND    8'hF1
`define RC_ST_LOCKED     2'h0
`define RC_ST_FIRST      2'h1
`define RC_ST_UNLOCKED   2'h2
`define RC_ST_DISABLED   2'h3
// address register fields
`define RC_ADR_BUSY      7
`define RC_ADR_AUTO_READ_ENABLE    6
`define RC_ADR_SHORT     4
`define RC_ADR_SHORT_RST 1'h1
// access timing in system clock cycles
`define RC_CYC_NORMAL    3'h7
`define RC_CYC_SHORT     3'h6
// internal register addresses
`define RC_IA_SNAP0      4'h0
`define RC_IA_SNAP3      4'h3
`define RC_IA_CTRL       4'h4
`define RC_IA_OSCCTL     4'h5
`define RC_IA_OSCCFG     4'h6
`define RC_IA_PINCFG     4'h7
`define RC_IA_ALARM0     4'h8
`define RC_IA_ALARM3     4'hB
// clock control fields
`define RC_CN_RUN        7
`define RC_CN_MISSEN     6
`define RC_CN_MISSFLG    5
`define RC_CN_ALARMEN    4
`define RC_CN_ALARMFLG   2
`define RC_CN_SET        1
`define RC_CN_CAPTURE    0
// oscillator config and pin config fields
`define RC_CF_AUTOSTEP   7
`define RC_CF_LOADCAP_HI 3
`define RC_PIN_SHORT     7
// reset values of internal registers
`define RC_CTRL_RST      8'h00
`define RC_OSC_RST       8'h00
`define RC_PIN_RST       8'h00
`endif

// ===== logic/rc_lock_fsm.v
// lock and key state machine guarding the indirect port
`timescale 1ns/1ps
`include "rc_regs.vh"
module rc_lock_fsm (
	// clock and reset
	input  wire       ref_clk,
	input  wire       rst_b,
	// key writes and access attempts
	input  wire       keyWr,
	input  wire [7:0] keyData,
	input  wire       accessTry,
	// status
	output wire [1:0] lockState,
	output wire       unlocked
);
	localparam ST_LOCKED   = `RC_ST_LOCKED;
	localparam ST_FIRST    = `RC_ST_FIRST;
	localparam ST_UNLOCKED = `RC_ST_UNLOCKED;
	localparam ST_DISABLED = `RC_ST_DISABLED;

	reg [1:0] stateQ;
	reg [1:0] stateD;

	// next state from key writes and locked accesses
	always @* begin
		stateD = stateQ;
		case (stateQ)
			ST_LOCKED: begin
				if (accessTry)
					stateD = ST_DISABLED;
				else if (keyWr)
					stateD = (keyData == `RC_KEY_FIRST) ?
						ST_FIRST : ST_DISABLED;
			end
			ST_FIRST: begin
				if (accessTry)
					stateD = ST_DISABLED;
				else if (keyWr)
					stateD = (keyData == `RC_KEY_SECOND) ?
						ST_UNLOCKED : ST_DISABLED;
			end
			ST_UNLOCKED: begin
				if (keyWr)
					stateD = ST_LOCKED;
			end
			default: stateD = ST_DISABLED;
		endcase
	end

	// state register, cleared by system reset or by a key write while unlocked
	always @(posedge ref_clk) begin
		if (!rst_b)
			stateQ <= ST_LOCKED;
		else
			stateQ <= stateD;
	end

	assign lockState = stateQ;
	assign unlocked  = (stateQ == ST_UNLOCKED);
endmodule // rc_lock_fsm

// ===== logic/rc_locked_port.v
// locked indirect access port of the real-time clock
//
// Operation
// - unlock by writing first then second key
// - bad key or locked access disables port
// - unlocked port allows unlimited indirect accesses
// - key write while unlocked relocks the port
// - key read shows status, sequence undisturbed
// - address register selects the internal register
// - data register write starts indirect write
// - setting busy bit starts indirect read
// - read data held until next access
// - address and data survive device reset
// - access takes 7 cycles, 6 short
// - short strobe on at reset, bit 4
// - autoread: data read launches next read
// - autoread follows address register bit 6
// - snapshot and alarm accesses advance address
// - bytes 0-3 snapshot, byte 4 control
// - bytes 8-11 hold the alarm value
// - oscillator config: 16 load levels, autostep
// - internal registers reachable only indirectly
// - alarm and missing-clock events for reset/wake
// - key read codes; disabled ignores key writes
`timescale 1ns/1ps
`include "rc_regs.vh"
module rc_locked_port #(
	parameter WIDTH = 32
) (
	// clock and reset
	input  wire       ref_clk,
	input  wire       rst_b,
	// special function register strobes
	input  wire       keyWr,
	input  wire       adrWr,
	input  wire       datWr,
	input  wire       datRd,
	input  wire [7:0] sfrWrData,
	// special function register read data
	output wire [7:0] keyRdData,
	output wire [7:0] adrRdData,
	output wire [7:0] datRdData,
	// timekeeping inputs
	input  wire       rtcTick,
	input  wire       oscMissing,
	// oscillator and pin controls
	output wire [7:0] oscCtlOut,
	output wire [3:0] loadCapSel,
	output wire       autoStepEn,
	output wire       shortCrystalPins,
	// events
	output wire       alarmEvent,
	output wire       missingEvent
);
	localparam NB = WIDTH / 8;
	// reset value of the control register, split into its stored bits
	localparam [7:0] CTRL_RST = `RC_CTRL_RST;

	//----------------------------------------------------------
	// lock and key
	//----------------------------------------------------------
	wire [1:0] lockState;
	wire       unlocked;
	wire       accessTry;

	// any indirect access strobe counts as an attempt
	assign accessTry = adrWr | datWr | datRd;

	rc_lock_fsm u_lock (
		.ref_clk   (ref_clk),
		.rst_b     (rst_b),
		.keyWr     (keyWr),
		.keyData   (sfrWrData),
		.accessTry (accessTry),
		.lockState (lockState),
		.unlocked  (unlocked)
	);

	// key read returns status with no side effect; the key register
	// has no read strobe, so reading it mid-sequence cannot upset the
	// lock machine
	assign keyRdData = {6'h00, lockState};

	//----------------------------------------------------------
	// interface registers
	//----------------------------------------------------------
	reg  [3:0] addrQ;
	reg        autoRdQ;
	reg        shortQ;
	reg        busyQ;
	reg  [2:0] cntQ;
	reg        isWrQ;
	reg  [7:0] datQ;
	wire       adrAcc;
	wire       datWrAcc;
	wire       datRdAcc;
	wire       startRd;
	wire       startWr;
	wire       done;
	wire       incAddr;
	wire       inSnap;
	wire       inAlarm;
	wire [7:0] rdByte;

	// strobes only act while unlocked and idle; an access that lands
	// during busy is dropped whole, so the address and data in flight
	// cannot change under the running transfer
	assign adrAcc   = adrWr & unlocked & ~busyQ;
	assign datWrAcc = datWr & unlocked & ~busyQ;
	assign datRdAcc = datRd & unlocked & ~busyQ;

	// launch of reads and writes
	assign startRd = (adrAcc & sfrWrData[`RC_ADR_BUSY]) |
		(datRdAcc & autoRdQ);
	assign startWr = datWrAcc;
	assign done    = busyQ && (cntQ == 3'h0);

	// address ranges that autoincrement: snapshot and alarm bytes
	assign inSnap  = (addrQ <= `RC_IA_SNAP3);
	assign inAlarm = (addrQ >= `RC_IA_ALARM0) &&
		(addrQ <= `RC_IA_ALARM3);

	// step on at completion so a multi-byte run needs one address write
	assign incAddr = done && (inSnap || inAlarm);

	// address and autoread keep their value across reset, so software
	// can resume a run after a device reset without rewriting them
	always @(posedge ref_clk) begin
		if (adrAcc) begin
			addrQ   <= sfrWrData[3:0];
			autoRdQ <= sfrWrData[`RC_ADR_AUTO_READ_ENABLE];
		end else if (incAddr) begin
			addrQ <= addrQ + 4'h1;
		end
	end

	// short strobe comes back on at every reset
	always @(posedge ref_clk) begin
		if (!rst_b)
			shortQ <= `RC_ADR_SHORT_RST;
		else if (adrAcc)
			shortQ <= sfrWrData[`RC_ADR_SHORT];
	end

	// access timer: busy for 7 or 6 cycles; the count is loaded with
	// one less because the launch edge already raises busy, and a new
	// address write takes its short bit at once
	always @(posedge ref_clk) begin
		if (!rst_b) begin
			busyQ <= 1'b0;
			cntQ  <= 3'h0;
			isWrQ <= 1'b0;
		end else if (startRd || startWr) begin
			busyQ <= 1'b1;
			isWrQ <= startWr;
			if (adrAcc ? sfrWrData[`RC_ADR_SHORT] : shortQ)
				cntQ <= `RC_CYC_SHORT - 3'h1;
			else
				cntQ <= `RC_CYC_NORMAL - 3'h1;
		end else if (done) begin
			busyQ <= 1'b0;
		end else if (busyQ) begin
			cntQ <= cntQ - 3'h1;
		end
	end

	// data register: written value, then read result; no reset, so a
	// result fetched before a device reset can still be read after it
	always @(posedge ref_clk) begin
		if (datWrAcc)
			datQ <= sfrWrData;
		else if (done && !isWrQ)
			datQ <= rdByte;
	end

	// reads of address and data hide contents unless unlocked
	assign adrRdData = unlocked ?
		{busyQ, autoRdQ, 1'b0, shortQ, addrQ} : 8'h00;
	assign datRdData = unlocked ? datQ : 8'h00;

	//----------------------------------------------------------
	// internal registers
	//----------------------------------------------------------
	reg  [WIDTH-1:0] snapQ;
	reg  [WIDTH-1:0] alarmQ;
	reg        runQ;
	reg        missEnQ;
	reg        alarmEnQ;
	reg  [7:0] oscCtlQ;
	reg  [7:0] oscCfgQ;
	reg  [7:0] pinCfgQ;
	reg        capPendQ;
	wire       wrDone;
	wire       ctrlWr;
	wire       loadPulse;
	wire       capPulse;
	wire [WIDTH-1:0] timerValue;
	wire       alarmFlag;
	wire       missFlag;
	wire [7:0] ctrlByte;

	// indirect write completes at the end of the access
	assign wrDone = done & isWrQ;
	assign ctrlWr = wrDone && (addrQ == `RC_IA_CTRL);

	// set and capture act once, never stored
	assign loadPulse = ctrlWr & datQ[`RC_CN_SET];
	assign capPulse  = ctrlWr & datQ[`RC_CN_CAPTURE];

	// snapshot and alarm byte lanes
	genvar i;
	generate
		for (i = 0; i < NB; i = i + 1) begin : g_lane
			// snapshot byte: indirect write or capture; an indirect
			// write wins over a capture in the same cycle
			always @(posedge ref_clk) begin
				if (!rst_b)
					snapQ[8*i+7:8*i] <= 8'h00;
				else if (wrDone && {28'h0000000, addrQ} == `RC_IA_SNAP0 + i)
					snapQ[8*i+7:8*i] <= datQ;
				else if (capPendQ)
					snapQ[8*i+7:8*i] <= timerValue[8*i+7:8*i];
			end
			// alarm compare byte
			always @(posedge ref_clk) begin
				if (!rst_b)
					alarmQ[8*i+7:8*i] <= 8'h00;
				else if (wrDone && {28'h0000000, addrQ} == `RC_IA_ALARM0 + i)
					alarmQ[8*i+7:8*i] <= datQ;
			end
		end
	endgenerate

	// capture copies the counter one cycle after the command, so the
	// snapshot shows the count after any load done by the same write
	always @(posedge ref_clk) begin
		if (!rst_b)
			capPendQ <= 1'b0;
		else
			capPendQ <= capPulse;
	end

	// control and oscillator registers; set and capture bits are not
	// stored, and writes to unmapped addresses are dropped
	always @(posedge ref_clk) begin
		if (!rst_b) begin
			runQ     <= CTRL_RST[`RC_CN_RUN];
			missEnQ  <= CTRL_RST[`RC_CN_MISSEN];
			alarmEnQ <= CTRL_RST[`RC_CN_ALARMEN];
			oscCtlQ  <= `RC_OSC_RST;
			oscCfgQ  <= `RC_OSC_RST;
			pinCfgQ  <= `RC_PIN_RST;
		end else if (wrDone) begin
			case (addrQ)
				`RC_IA_CTRL: begin
					runQ     <= datQ[`RC_CN_RUN];
					missEnQ  <= datQ[`RC_CN_MISSEN];
					alarmEnQ <= datQ[`RC_CN_ALARMEN];
				end
				`RC_IA_OSCCTL: oscCtlQ <= datQ;
				`RC_IA_OSCCFG: oscCfgQ <= datQ;
				`RC_IA_PINCFG: pinCfgQ <= datQ;
				default: pinCfgQ <= pinCfgQ;
			endcase
		end
	end

	//----------------------------------------------------------
	// timekeeping core
	//----------------------------------------------------------
	// counter, alarm compare and sticky event flags; the set command
	// loads the counter from the snapshot bytes
	rc_timer_core #(
		.WIDTH (WIDTH)
	) u_core (
		.ref_clk    (ref_clk),
		.rst_b      (rst_b),
		.tick       (rtcTick),
		.runEn      (runQ),
		.alarmEn    (alarmEnQ),
		.missEn     (missEnQ),
		.oscMissing (oscMissing),
		.loadPulse  (loadPulse),
		.loadValue  (snapQ),
		.alarmValue (alarmQ),
		.alarmClr   (ctrlWr & ~datQ[`RC_CN_ALARMFLG]),
		.missClr    (ctrlWr & ~datQ[`RC_CN_MISSFLG]),
		.timerValue (timerValue),
		.alarmFlag  (alarmFlag),
		.missFlag   (missFlag)
	);

	// control byte as read back
	assign ctrlByte = {runQ, missEnQ, missFlag, alarmEnQ,
		1'b0, alarmFlag, 2'b00};

	//----------------------------------------------------------
	// indirect read selection
	//----------------------------------------------------------
	reg [7:0] rdSel;

	// byte chosen by the current address; unmapped addresses read
	// zero so a stray autoread run returns a known value
	always @* begin
		rdSel = 8'h00;
		case (addrQ)
			4'h0: rdSel = snapQ[7:0];
			4'h1: rdSel = snapQ[15:8];
			4'h2: rdSel = snapQ[23:16];
			4'h3: rdSel = snapQ[31:24];
			`RC_IA_CTRL:   rdSel = ctrlByte;
			`RC_IA_OSCCTL: rdSel = oscCtlQ;
			`RC_IA_OSCCFG: rdSel = oscCfgQ;
			`RC_IA_PINCFG: rdSel = pinCfgQ;
			4'h8: rdSel = alarmQ[7:0];
			4'h9: rdSel = alarmQ[15:8];
			4'hA: rdSel = alarmQ[23:16];
			4'hB: rdSel = alarmQ[31:24];
			default: rdSel = 8'h00;
		endcase
	end
	assign rdByte = rdSel;

	//----------------------------------------------------------
	// outputs
	//----------------------------------------------------------
	// oscillator, load capacitance and pin controls, straight from
	// their registers
	assign oscCtlOut  = oscCtlQ;
	assign loadCapSel = oscCfgQ[`RC_CF_LOADCAP_HI:0];
	assign autoStepEn = oscCfgQ[`RC_CF_AUTOSTEP];
	assign shortCrystalPins = pinCfgQ[`RC_PIN_SHORT];

	// event levels for reset and wake-up routing; they stay high
	// until software writes the flag bit to zero
	assign alarmEvent   = alarmFlag;
	assign missingEvent = missFlag;
endmodule // rc_locked_port

// ===== logic/rc_timer_core.v
// 32-bit timekeeping counter with alarm and missing-clock flags
`timescale 1ns/1ps
`include "rc_regs.vh"
module rc_timer_core #(
	parameter WIDTH = 32
) (
	// clock and reset
	input  wire             ref_clk,
	input  wire             rst_b,
	// control
	input  wire             tick,
	input  wire             runEn,
	input  wire             alarmEn,
	input  wire             missEn,
	input  wire             oscMissing,
	input  wire             loadPulse,
	input  wire [WIDTH-1:0] loadValue,
	input  wire [WIDTH-1:0] alarmValue,
	input  wire             alarmClr,
	input  wire             missClr,
	// status
	output wire [WIDTH-1:0] timerValue,
	output wire             alarmFlag,
	output wire             missFlag
);
	reg [WIDTH-1:0] timerQ;
	reg             alarmQ;
	reg             missQ;
	wire            alarmHit;

	assign alarmHit = runEn && alarmEn && (timerQ == alarmValue);

	// counter loads from the snapshot bytes or counts ticks
	always @(posedge ref_clk) begin
		if (!rst_b)
			timerQ <= {WIDTH{1'b0}};
		else if (loadPulse)
			timerQ <= loadValue;
		else if (runEn && tick)
			timerQ <= timerQ + {{(WIDTH-1){1'b0}}, 1'b1};
	end

	// sticky event flags, a new event beats a clear
	always @(posedge ref_clk) begin
		if (!rst_b) begin
			alarmQ <= 1'b0;
			missQ  <= 1'b0;
		end else begin
			alarmQ <= alarmHit | (alarmQ & ~alarmClr);
			missQ  <= (missEn & oscMissing) |
				(missQ & ~missClr);
		end
	end

	assign timerValue = timerQ;
	assign alarmFlag  = alarmQ;
	assign missFlag   = missQ;
endmodule // rc_timer_core

// ===== tb/rc_cpu_model.sv
// processor core model driving the special function register strobes
`timescale 1ns/1ps
module rc_cpu_model (
	// clock and read data
	input  wire       ref_clk,
	input  wire [7:0] adrRdData,
	input  wire [7:0] datRdData,
	// strobes and write data
	output reg        keyWr,
	output reg        adrWr,
	output reg        datWr,
	output reg        datRd,
	output reg  [7:0] sfrWrData
);
	initial begin
		{keyWr, adrWr, datWr, datRd} = 4'h0;
		sfrWrData = 8'h00;
	end
	// one-cycle write strobe; sel one-hot key, address, data
	task sfrW(input [2:0] sel, input [7:0] d);
		begin
			@(posedge ref_clk);
			{keyWr, adrWr, datWr} <= sel;
			sfrWrData <= d;
			@(posedge ref_clk);
			{keyWr, adrWr, datWr} <= 3'h0;
			sfrWrData <= ~d; // released bus shows no stale value
		end
	endtask
	// data register read, data taken at the strobe's edge
	task datR(output [7:0] d);
		begin
			@(posedge ref_clk);
			datRd <= 1'b1;
			@(posedge ref_clk);
			d = datRdData;
			datRd <= 1'b0;
		end
	endtask
	// poll busy before the next access, return cycles seen busy
	task waitIdle(output integer n);
		begin
			#1;
			n = 0;
			while (adrRdData[7] !== 1'b0 && n < 20) begin
				n = n + 1;
				@(posedge ref_clk);
				#1;
			end
		end
	endtask
endmodule // rc_cpu_model

// ===== tb/rc_locked_port_bench.sv
// self-checking bench for the locked indirect port
`timescale 1ns/1ps
module rc_locked_port_bench;
	reg         ref_clk;
	reg         rst_b;
	reg         rtcTick;
	reg         oscMissing;
	wire        keyWr, adrWr, datWr, datRd;
	wire [7:0]  sfrWrData, keyRdData, adrRdData, datRdData;
	wire [7:0]  oscCtlOut;
	wire [3:0]  loadCapSel;
	wire        autoStepEn, shortCrystalPins, alarmEvent, missingEvent;
	integer     err_count = 0;
	integer     n_tests = 0;
	integer     cycles = 0;
	integer     n, i;
	reg  [7:0]  rd;

	rc_locked_port #(.WIDTH(32)) i_rc_locked_port (
		.ref_clk(ref_clk), .rst_b(rst_b), .keyWr(keyWr), .adrWr(adrWr),
		.datWr(datWr), .datRd(datRd), .sfrWrData(sfrWrData),
		.keyRdData(keyRdData), .adrRdData(adrRdData),
		.datRdData(datRdData), .rtcTick(rtcTick), .oscMissing(oscMissing),
		.oscCtlOut(oscCtlOut), .loadCapSel(loadCapSel),
		.autoStepEn(autoStepEn), .shortCrystalPins(shortCrystalPins),
		.alarmEvent(alarmEvent), .missingEvent(missingEvent));
	rc_cpu_model i_rc_cpu_model (
		.ref_clk(ref_clk), .adrRdData(adrRdData), .datRdData(datRdData),
		.keyWr(keyWr), .adrWr(adrWr), .datWr(datWr), .datRd(datRd),
		.sfrWrData(sfrWrData));

	// ----------------------------------------
	// clock, timeout and common tasks
	// ----------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cycles = cycles + 1;
		if (cycles == 3000) begin
			err_count = err_count + 1;
			finish_test;
		end
	end
	task chk8(input [7:0] got, input [7:0] exp);
		begin
			n_tests = n_tests + 1;
			if (got !== exp) begin
				err_count = err_count + 1;
				$display("[FAIL] %0t got %h want %h", $time, got, exp);
			end
		end
	endtask
	task doReset;
		begin
			@(posedge ref_clk);
			rst_b <= 1'b0;
			repeat (6) @(posedge ref_clk);
			rst_b <= 1'b1;
		end
	endtask
	task finish_test;
		begin
			$display("mismatches %0d comparisons %0d", err_count, n_tests);
			if (err_count == 0 && n_tests > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	// unlock sequence and short strobe default
	task t_unlock;
		begin
			#1 chk8(keyRdData, 8'h00);
			i_rc_cpu_model.sfrW(3'h4, 8'hA5);
			#1 chk8(keyRdData, 8'h01);
			i_rc_cpu_model.sfrW(3'h4, 8'hF1);
			#1 chk8(keyRdData, 8'h02);
			chk8({7'h00, adrRdData[4]}, 8'h01);
		end
	endtask
	// alarm bytes written, read normal, then autoread run
	task t_alarm;
		begin
			i_rc_cpu_model.sfrW(3'h2, 8'h18);
			for (i = 0; i < 4; i = i + 1) begin
				i_rc_cpu_model.sfrW(3'h1, 8'h11 * (i + 1));
				i_rc_cpu_model.waitIdle(n);
				chk8(n[7:0], 8'h06);
			end
			chk8({4'h0, adrRdData[3:0]}, 8'h0C);
			i_rc_cpu_model.sfrW(3'h2, 8'h88);
			i_rc_cpu_model.waitIdle(n);
			chk8(n[7:0], 8'h07);
			chk8(datRdData, 8'h11);
			chk8({4'h0, adrRdData[3:0]}, 8'h09);
			i_rc_cpu_model.sfrW(3'h2, 8'h58);
			#1 chk8(datRdData, 8'h11);
			i_rc_cpu_model.sfrW(3'h2, 8'hD8);
			i_rc_cpu_model.waitIdle(n);
			for (i = 0; i < 4; i = i + 1) begin
				i_rc_cpu_model.datR(rd);
				chk8(rd, 8'h11 * (i + 1));
				i_rc_cpu_model.waitIdle(n);
				chk8(n[7:0], 8'h06);
			end
			chk8({4'h0, adrRdData[3:0]}, 8'h0C);
		end
	endtask
	// data register write, then wait for the indirect write to finish
	task wrDat(input [7:0] d);
		begin
			i_rc_cpu_model.sfrW(3'h1, d);
			i_rc_cpu_model.waitIdle(n);
		end
	endtask
	// short indirect read of one internal register
	task rdInt(input [3:0] a);
		begin
			i_rc_cpu_model.sfrW(3'h2, {4'h9, a});
			i_rc_cpu_model.waitIdle(n);
		end
	endtask
	// oscillator, pin, timer, alarm and missing-clock registers
	task t_internal;
		begin
			i_rc_cpu_model.sfrW(3'h2, 8'h15);
			wrDat(8'h5A);
			chk8(oscCtlOut, 8'h5A);
			i_rc_cpu_model.sfrW(3'h2, 8'h16);
			wrDat(8'h8B);
			chk8({autoStepEn, 3'h0, loadCapSel}, 8'h8B);
			i_rc_cpu_model.sfrW(3'h2, 8'h17);
			wrDat(8'h80);
			chk8({7'h00, shortCrystalPins}, 8'h01);
			i_rc_cpu_model.sfrW(3'h2, 8'h10);
			wrDat(8'h0F);
			wrDat(8'h22);
			wrDat(8'h33);
			wrDat(8'h44);
			chk8({4'h0, adrRdData[3:0]}, 8'h04);
			wrDat(8'h92);
			chk8({7'h00, alarmEvent}, 8'h00);
			@(posedge ref_clk);
			rtcTick <= 1'b1;
			repeat (2) @(posedge ref_clk);
			rtcTick <= 1'b0;
			@(posedge ref_clk);
			#1 chk8({7'h00, alarmEvent}, 8'h01);
			wrDat(8'h91);
			rdInt(4'h0);
			chk8(datRdData, 8'h11);
			rdInt(4'h4);
			chk8(datRdData, 8'h94);
			// run still on as this write lands, so the alarm set wins
			wrDat(8'h40);
			@(posedge ref_clk);
			oscMissing <= 1'b1;
			@(posedge ref_clk);
			oscMissing <= 1'b0;
			@(posedge ref_clk);
			#1 chk8({6'h00, missingEvent, alarmEvent}, 8'h03);
		end
	endtask
	// relock, locked access, then key writes ignored
	task t_relock;
		begin
			i_rc_cpu_model.sfrW(3'h4, 8'h00);
			#1 chk8(keyRdData, 8'h00);
			i_rc_cpu_model.sfrW(3'h2, 8'h80);
			#1 chk8(keyRdData, 8'h03);
			chk8(adrRdData, 8'h00);
			i_rc_cpu_model.sfrW(3'h1, 8'h00);
			repeat (8) @(posedge ref_clk);
			#1 chk8({6'h00, missingEvent, alarmEvent}, 8'h03);
			i_rc_cpu_model.sfrW(3'h4, 8'hA5);
			#1 chk8(keyRdData, 8'h03);
		end
	endtask
	// address kept over reset, then a wrong second key
	task t_retain;
		begin
			doReset;
			t_unlock;
			chk8({4'h0, adrRdData[3:0]}, 8'h04);
			chk8(datRdData, 8'h40);
			doReset;
			i_rc_cpu_model.sfrW(3'h4, 8'hA5);
			i_rc_cpu_model.sfrW(3'h4, 8'h77);
			#1 chk8(keyRdData, 8'h03);
		end
	endtask

	initial begin
		rst_b = 1'b0;
		rtcTick = 1'b0;
		oscMissing = 1'b0;
		doReset;
		t_unlock;
		t_alarm;
		t_internal;
		t_relock;
		t_retain;
		finish_test;
	end
endmodule // rc_locked_port_bench

// ===== tb/rc_lp_checker_assertions.sv
// concurrent checks on the ports of the locked indirect port
`timescale 1ns/1ps
`include "rc_regs.vh"
module rc_lp_checker (
	// clock and reset
	input wire       ref_clk,
	input wire       rst_b,
	// strobes and data
	input wire       keyWr,
	input wire       adrWr,
	input wire       datWr,
	input wire       datRd,
	input wire [7:0] sfrWrData,
	input wire [7:0] keyRdData,
	input wire [7:0] adrRdData,
	input wire [7:0] datRdData
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// launch of an indirect read on an idle open port
	wire rdGo = adrWr && sfrWrData[7] && keyRdData == 8'h02 && !adrRdData[7];
	wire anyAcc = adrWr || datWr || datRd;

	key_upper_a: assert property (keyRdData[7:2] == 6'h00)
		else $error("key status upper bits not zero");
	first_key_a: assert property (keyWr && sfrWrData == `RC_KEY_FIRST &&
		keyRdData == 8'h00 |=> keyRdData == 8'h01)
		else $error("first key not taken");
	unlock_key_a: assert property (keyWr && sfrWrData == `RC_KEY_SECOND &&
		keyRdData == 8'h01 |=> keyRdData == 8'h02)
		else $error("second key did not unlock");
	bad_key_a: assert property (keyWr && sfrWrData != `RC_KEY_SECOND &&
		keyRdData == 8'h01 |=> keyRdData == 8'h03)
		else $error("wrong second key did not disable");
	relock_key_a: assert property (keyWr && keyRdData == 8'h02
		|=> keyRdData == 8'h00)
		else $error("key write did not relock");
	disabled_hold_a: assert property (keyRdData == 8'h03
		|=> $stable(keyRdData))
		else $error("disabled state left without reset");
	locked_access_a: assert property (anyAcc && !keyWr && keyRdData < 8'h02
		|=> keyRdData == 8'h03)
		else $error("locked access did not disable");
	locked_hide_a: assert property (keyRdData != 8'h02
		|-> adrRdData == 8'h00 && datRdData == 8'h00)
		else $error("registers visible while not open");
	short_busy_a: assert property (rdGo && sfrWrData[4]
		|=> adrRdData[7] [*6] ##1 !adrRdData[7])
		else $error("short read not six cycles");
	long_busy_a: assert property (rdGo && !sfrWrData[4]
		|=> adrRdData[7] [*7] ##1 !adrRdData[7])
		else $error("normal read not seven cycles");
endmodule // rc_lp_checker

bind rc_locked_port rc_lp_checker i_rc_lp_checker (
	.ref_clk(ref_clk), .rst_b(rst_b), .keyWr(keyWr), .adrWr(adrWr),
	.datWr(datWr), .datRd(datRd), .sfrWrData(sfrWrData),
	.keyRdData(keyRdData), .adrRdData(adrRdData), .datRdData(datRdData));
